// ### hw/pstc_checker.v
`timescale 1ns/1ps
`default_nettype none
`include "pstc_regs.vh"
module pstc_checker #(
  parameter DW = 16,
  parameter EW = `PSTC_ERR_W
) (
  input  wire          mclk,
  input  wire          rstn,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [7:0]    wb_adr_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  input  wire [DW-1:0] portData,
  input  wire          portValid,
  input  wire          portClk,
  output wire          testActive
);
  // ***************************************************
  // states
  // ***************************************************
  localparam [1:0] ST_WAIT = 2'b00;
  localparam [1:0] ST_SEED = 2'b01;
  localparam [1:0] ST_CMP  = 2'b10;
  localparam [1:0] ST_OFF  = 2'b11;

  function [15:0] nextRef;
    input [15:0] v;
    reg   [15:0] t;
    begin
      t = v ^ (v << `PSTC_SH_A);
      t = t ^ (t >> `PSTC_SH_B);
      nextRef = t ^ (t << `PSTC_SH_C);
    end
  endfunction

  // ***************************************************
  // input synchronisers
  // ***************************************************
  reg [DW-1:0] dataS1_q;
  reg [DW-1:0] dataS2_q;
  reg          validS1_q;
  reg          validS2_q;
  reg          validS3_q;
  reg          clkS1_q;
  reg          clkS2_q;
  reg          clkS3_q;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      dataS1_q  <= {DW{1'b0}};
      dataS2_q  <= {DW{1'b0}};
      validS1_q <= 1'b0;
      validS2_q <= 1'b0;
      validS3_q <= 1'b0;
      clkS1_q   <= 1'b0;
      clkS2_q   <= 1'b0;
      clkS3_q   <= 1'b0;
    end
    else
    begin
      dataS1_q  <= portData;
      dataS2_q  <= dataS1_q;
      validS1_q <= portValid;
      validS2_q <= validS1_q;
      validS3_q <= validS2_q;
      clkS1_q   <= portClk;
      clkS2_q   <= clkS1_q;
      clkS3_q   <= clkS2_q;
    end
  end

  wire clkRise = clkS2_q & ~clkS3_q;
  wire clkFall = ~clkS2_q & clkS3_q;

  // ***************************************************
  // control registers
  // ***************************************************
  reg        testEn_q;
  reg [3:0]  streamEn_q;
  reg [1:0]  segSrc_q;
  reg [31:0] rate_q;
  reg [3:0]  errSel_q;
  wire       wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wbWr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;  // lands on the edge the master sees ack
  wire [3:0] newStream = wb_dat_i[`PSTC_CTRL_PDW:`PSTC_CTRL_IQ];
  // an enable is refused while another mode runs, so the port never splits
  wire       streamOk = (newStream == 4'h0) ||
                        (((newStream & (newStream - 4'h1)) == 4'h0) &&
                         ((streamEn_q == 4'h0) || (streamEn_q == newStream)));

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      testEn_q   <= 1'b0;
      streamEn_q <= 4'h0;
      segSrc_q   <= `PSTC_SRC_INT;
      rate_q     <= `PSTC_RATE_RST;
      errSel_q   <= 4'h0;
      wb_ack_o   <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wbReq;
      if (wbWr && wb_sel_i[0] && wb_adr_i == `PSTC_CTRL_OFS)
      begin
        testEn_q <= wb_dat_i[`PSTC_CTRL_TEST];
        segSrc_q <= wb_dat_i[`PSTC_CTRL_SRC_HI:`PSTC_CTRL_SRC_LO];
        if (streamOk)
          streamEn_q <= newStream;
      end
      if (wbWr && wb_sel_i[0] && wb_adr_i == `PSTC_ERRSEL_OFS)
        errSel_q <= wb_dat_i[3:0];
      if (wbWr && wb_adr_i == `PSTC_RATE_OFS)
      begin
        if (wb_sel_i[0]) rate_q[7:0]   <= wb_dat_i[7:0];
        if (wb_sel_i[1]) rate_q[15:8]  <= wb_dat_i[15:8];
        if (wb_sel_i[2]) rate_q[23:16] <= wb_dat_i[23:16];
        if (wb_sel_i[3]) rate_q[31:24] <= wb_dat_i[31:24];
      end
    end
  end

  wire iqMode  = streamEn_q[0];
  wire segMode = streamEn_q[1];
  wire descMode = streamEn_q[2] | streamEn_q[3];
  assign testActive = testEn_q;

  // ***************************************************
  // port clock lock monitor
  // ***************************************************
  reg [7:0] highCnt_q;
  reg [7:0] lowCnt_q;
  reg [7:0] highLen_q;
  reg [7:0] goodCnt_q;
  reg       locked_q;
  reg       freqOk_q;
  wire [7:0] perLen = highLen_q + lowCnt_q;
  wire      dutyOk = (highLen_q == lowCnt_q) || (highLen_q == lowCnt_q + 8'h01) ||
                     (highLen_q + 8'h01 == lowCnt_q);
  wire      perOk  = (perLen >= `PSTC_PER_MIN) && (perLen <= `PSTC_PER_MAX);

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      highCnt_q <= 8'h00;
      lowCnt_q  <= 8'h00;
      highLen_q <= 8'h00;
      goodCnt_q <= 8'h00;
      locked_q  <= 1'b0;
      freqOk_q  <= 1'b0;
    end
    else
    begin
      if (clkS2_q && highCnt_q != 8'hFF)
        highCnt_q <= highCnt_q + 8'h01;
      if (!clkS2_q && lowCnt_q != 8'hFF)
        lowCnt_q <= lowCnt_q + 8'h01;
      if (clkFall)
      begin
        highLen_q <= highCnt_q;
        lowCnt_q  <= 8'h00;
      end
      if (clkRise)
      begin
        highCnt_q <= 8'h00;
        freqOk_q  <= perOk;
        // lock needs several clean periods in a row
        if (dutyOk && perOk)
        begin
          if (goodCnt_q != `PSTC_LOCK_PERIODS)
            goodCnt_q <= goodCnt_q + 8'h01;
          else
            locked_q <= 1'b1;
        end
        else
        begin
          goodCnt_q <= 8'h00;
          locked_q  <= 1'b0;
        end
      end
      // a stopped clock drops lock
      if (highCnt_q == 8'hFF || lowCnt_q == 8'hFF)
      begin
        goodCnt_q <= 8'h00;
        locked_q  <= 1'b0;
        freqOk_q  <= 1'b0;
      end
    end
  end

  // ***************************************************
  // iq pattern checker
  // ***************************************************
  reg [1:0]  state_q;
  reg [15:0] refI_q;
  reg [15:0] refQ_q;
  reg        phaseQ_q;
  wire       iqWord = iqMode & clkRise & validS2_q;
  // valid low resets the word phase so the next word is I
  wire       wordIsQ = phaseQ_q & validS3_q;
  wire [15:0] expWord = wordIsQ ? refQ_q : refI_q;
  wire       doCmp = iqWord && state_q == ST_CMP && testEn_q;
  wire [15:0] errBits = doCmp ? (dataS2_q ^ expWord) : 16'h0000;
  wire       clrErr;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q  <= ST_OFF;
      refI_q   <= `PSTC_SEED_I;
      refQ_q   <= `PSTC_SEED_Q;
      phaseQ_q <= 1'b0;
    end
    else
    begin
      if (iqWord)
        phaseQ_q <= ~wordIsQ;
      else if (!validS2_q)
        phaseQ_q <= 1'b0;
      case (state_q)
        ST_OFF:
        begin
          if (testEn_q && iqMode)
            state_q <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (iqWord && !wordIsQ && dataS2_q == `PSTC_SEED_I)
            state_q <= ST_SEED;
        end
        ST_SEED:
        begin
          if (iqWord)
          begin
            if (dataS2_q == `PSTC_SEED_Q)
            begin
              state_q <= ST_CMP;
              refI_q  <= nextRef(`PSTC_SEED_I);
              refQ_q  <= nextRef(`PSTC_SEED_Q);
            end
            else
              state_q <= ST_WAIT;
          end
        end
        ST_CMP:
        begin
          // refs hold while valid is low, so comparison resumes in place
          if (iqWord)
          begin
            if (wordIsQ)
              refQ_q <= nextRef(refQ_q);
            else
              refI_q <= nextRef(refI_q);
          end
        end
        default:
          state_q <= ST_OFF;
      endcase
      if (!testEn_q || !iqMode)
        state_q <= ST_OFF;
    end
  end

  assign clrErr = (state_q == ST_SEED) && iqWord && (dataS2_q == `PSTC_SEED_Q);

  // ***************************************************
  // per-bit error counters
  // ***************************************************
  wire [EW-1:0] errCnt [0:DW-1];
  genvar b;
  generate
    for (b = 0; b < DW; b = b + 1)
    begin : g_err
      reg [EW-1:0] cnt_q;
      always @(posedge mclk or negedge rstn)
      begin
        if (!rstn)
          cnt_q <= {EW{1'b0}};
        else if (clrErr)
          cnt_q <= {EW{1'b0}};
        else if (errBits[b])
          cnt_q <= cnt_q + {{(EW-1){1'b0}}, 1'b1};
      end
      assign errCnt[b] = cnt_q;
    end
  endgenerate

  // ***************************************************
  // segment and descriptor capture
  // ***************************************************
  reg [15:0] segWord_q;
  reg [15:0] descWord_q;
  reg [15:0] descCnt_q;

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      segWord_q  <= 16'h0000;
      descWord_q <= 16'h0000;
      descCnt_q  <= 16'h0000;
    end
    else
    begin
      // sampled on mclk, never on the forwarded clock
      if (segMode)
        segWord_q <= dataS2_q;
      // a synchronised valid edge cannot repeat within the 4 ns floor
      if (descMode && validS2_q && !validS3_q)
      begin
        descWord_q <= dataS2_q;
        descCnt_q  <= descCnt_q + 16'h0001;
      end
      if (!descMode)
        descCnt_q <= 16'h0000;
    end
  end

  // ***************************************************
  // register read mux
  // ***************************************************
  reg [31:0] rdData;

  always @*
  begin
    rdData = 32'h00000000;
    case (wb_adr_i)
      `PSTC_CTRL_OFS:
        rdData = {25'h0, segSrc_q, streamEn_q, testEn_q};
      `PSTC_RATE_OFS:
        rdData = rate_q;
      `PSTC_STAT_OFS:
      begin
        rdData[`PSTC_STAT_VALID] = validS2_q;
        rdData[`PSTC_STAT_ST_HI:`PSTC_STAT_ST_LO] = state_q;
        rdData[`PSTC_STAT_LOCK] = locked_q;
        rdData[`PSTC_STAT_FREQ] = freqOk_q;
        rdData[`PSTC_STAT_TEST] = testEn_q;
        rdData[31:`PSTC_STAT_WD_LO] = segWord_q;
      end
      `PSTC_ERRSEL_OFS:
        rdData = {28'h0000000, errSel_q};
      `PSTC_ERRCNT_OFS:
        rdData = {{(32-EW){1'b0}}, errCnt[errSel_q]};
      `PSTC_DESC_OFS:
        rdData = {descCnt_q, descWord_q};
      default:
        rdData = 32'h00000000;
    endcase
  end

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      wb_dat_o <= 32'h00000000;
    else if (wbReq && !wb_we_i)
      wb_dat_o <= rdData;
  end
endmodule
`default_nettype wire

// ### hw/pstc_regs.vh
`ifndef PSTC_REGS_VH
`define PSTC_REGS_VH
// ***************************************************
// register offsets (byte addresses)
// ***************************************************
`define PSTC_CTRL_OFS     8'h00
`define PSTC_RATE_OFS     8'h04
`define PSTC_STAT_OFS     8'h08
`define PSTC_ERRSEL_OFS   8'h0C
`define PSTC_ERRCNT_OFS   8'h10
`define PSTC_DESC_OFS     8'h14
// ***************************************************
// control fields
// ***************************************************
`define PSTC_CTRL_TEST    0
`define PSTC_CTRL_IQ      1
`define PSTC_CTRL_SEG     2
`define PSTC_CTRL_CDW     3
`define PSTC_CTRL_PDW     4
`define PSTC_CTRL_SRC_LO  5
`define PSTC_CTRL_SRC_HI  6
// ***************************************************
// segment select sources
// ***************************************************
`define PSTC_SRC_INT      2'h0
`define PSTC_SRC_PORT     2'h1
`define PSTC_SRC_SEQ      2'h2
`define PSTC_SRC_MF       2'h3
// ***************************************************
// status fields
// ***************************************************
`define PSTC_STAT_VALID   0
`define PSTC_STAT_ST_LO   1
`define PSTC_STAT_ST_HI   2
`define PSTC_STAT_LOCK    3
`define PSTC_STAT_FREQ    4
`define PSTC_STAT_TEST    5
`define PSTC_STAT_WD_LO   16
// ***************************************************
// reset values, pattern constants and error counter width
// ***************************************************
`define PSTC_RATE_RST     32'h07735940
`define PSTC_SEED_I       16'h306C
`define PSTC_SEED_Q       16'hFFFF
`define PSTC_SH_A         7
`define PSTC_SH_B         9
`define PSTC_SH_C         8
`define PSTC_ERR_W        21
// ***************************************************
// timing
// ***************************************************
`define PSTC_MCLK_HZ      50000000
`define PSTC_MIN_TOGGLE_NS 4
`define PSTC_MIN_TOGGLE_CYC ((`PSTC_MIN_TOGGLE_NS * `PSTC_MCLK_HZ + 999999999) / 1000000000)
`define PSTC_LOCK_PERIODS 8'h08
`define PSTC_PER_MIN      8'h04
`define PSTC_PER_MAX      8'h40
`endif

// ### sim/pstc_checker_props.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// bus and status checks
// *****
module pstc_checker_props (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        portValid,
  input wire logic        testActive
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_stat_rd;
    wb_ack_o && !wb_we_i && wb_adr_i == 8'h08;
  endsequence
  sequence s_ctrl_wr;
    wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0];
  endsequence
  a_ack_after_take: assert property (s_take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h14 |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_test_bit_copy: assert property (s_ctrl_wr |=> testActive == $past(wb_dat_i[0]))
    else $error("test enable not taken");
  a_stat_test_flag: assert property (s_stat_rd |-> wb_dat_o[5] == testActive)
    else $error("status test flag wrong");
  a_stat_valid_seen: assert property ($stable(portValid)[*6] ##0 s_stat_rd |-> wb_dat_o[0] == portValid)
    else $error("status valid flag wrong");
  a_reset_test_off: assert property ($rose(rstn) |-> !testActive && !wb_ack_o)
    else $error("test enable on after reset");
endmodule
bind pstc_checker pstc_checker_props chk_u (
  .mclk(mclk),
  .rstn(rstn),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .portValid(portValid),
  .testActive(testActive)
);
`default_nettype wire

// ### sim/pstc_port_source.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// port source model
// *****
module pstc_port_source (
  output var logic [15:0] portData,
  output var logic        portValid,
  output var logic        portClk
);
  logic        clkOn;
  logic [15:0] refI;
  logic [15:0] refQ;
  function automatic logic [15:0] nxt(input logic [15:0] v);
    logic [15:0] t;
    begin
      t = v ^ (v << 7);
      t = t ^ (t >> 9);
      nxt = t ^ (t << 8);
    end
  endfunction
  initial
  begin
    clkOn = 1'b0;
    portClk = 1'b0;
    portValid = 1'b0; // low during setup
    portData = 16'h0000;
    refI = 16'h306C;
    refQ = 16'hFFFF;
  end
  // clock parks low while clk_run is off, 50 percent duty while it is on
  always #80 portClk = clkOn ? ~portClk : 1'b0;
  task automatic clk_run(input logic on);
    clkOn = on;
  endtask
  task automatic iq(input int n, input logic [15:0] flip);
    begin
      repeat (n)
      begin
        @(negedge portClk);
        portValid = 1'b1; // valid rises with an I word
        portData = refI ^ flip;
        refI = nxt(refI);
        @(negedge portClk);
        portData = refQ ^ flip;
        refQ = nxt(refQ);
      end
      @(negedge portClk);
      idle();
    end
  endtask
  task automatic idle();
    begin
      #7; // step off the block clock's sampling edge
      portValid = 1'b0;
      portData = ~portData; // released lines show no stale word
    end
  endtask
  task automatic seg(input logic [15:0] w);
    begin
      #7;
      portData = w;
      portValid = 1'b1;
    end
  endtask
  task automatic pulse(input logic [15:0] w);
    begin
      #7;
      portData = w; // address 15:8, parameter 7:0
      #40 portValid = 1'b1; // rises after data is stable
      #80 idle();
      #80;
    end
  endtask
endmodule
`default_nettype wire

// ### sim/tb_port_stream_test_checker.sv
`timescale 1ns/1ps
`default_nettype none
// *****
// bench
// *****
module tb_port_stream_test_checker;
  logic        mclk;
  logic        rstn;
  logic        wbCyc;
  logic        wbStb;
  logic        wbWe;
  logic [7:0]  wbAdr;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic        wbAck;
  logic [15:0] portData;
  logic        portValid;
  logic        portClk;
  logic        testActive;
  logic [31:0] rd;
  int          miscompares;
  int          n_compared;
  localparam logic [15:0] COMMIT_WORD = 16'h00FF; // arbitrary descriptor commit code
  pstc_checker dut_u (
    .mclk(mclk),
    .rstn(rstn),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_we_i(wbWe),
    .wb_adr_i(wbAdr),
    .wb_sel_i(4'hF),
    .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck),
    .portData(portData),
    .portValid(portValid),
    .portClk(portClk),
    .testActive(testActive)
  );
  pstc_port_source src_u (
    .portData(portData),
    .portValid(portValid),
    .portClk(portClk)
  );
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    begin
      if (miscompares == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_compared++;
      if (got !== exp)
      begin
        miscompares++;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge mclk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatI <= d;
      n = 0;
      do
      begin
        @(posedge mclk);
        n++;
      end
      while (wbAck !== 1'b1 && n < 50);
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      if (n >= 50)
      begin
        miscompares++;
        $display("ERROR %0t: no bus answer", $time);
        tally_and_finish();
      end
    end
  endtask
  task automatic chk_reset();
    begin
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      wb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h07735940);
      wb(1'b0, 8'h08, 32'h0);
      chk({30'h0, rd[2:1]}, 32'h3);
      wb(1'b1, 8'h40, 32'hFFFFFFFF);
      wb(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0);
    end
  endtask
  task automatic chk_modes();
    begin
      for (int b = 0; b < 4; b++)
      begin
        wb(1'b1, 8'h00, (b << 5) | (2 << b));
        wb(1'b0, 8'h00, 32'h0);
        chk(rd, (b << 5) | (2 << b));
        wb(1'b1, 8'h00, 32'h0);
      end
      wb(1'b1, 8'h00, 32'h06);
      wb(1'b1, 8'h00, 32'h02);
      wb(1'b1, 8'h00, 32'h64);
      wb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h62);
      wb(1'b1, 8'h00, 32'h0);
    end
  endtask
  task automatic chk_iq();
    begin
      src_u.clk_run(1'b1);
      wb(1'b1, 8'h00, 32'h03);
      repeat (150) @(posedge mclk);
      wb(1'b0, 8'h08, 32'h0);
      chk({26'h0, rd[5:0]}, 32'h38);
      src_u.iq(3, 16'h0);
      repeat (8) @(posedge mclk);
      wb(1'b0, 8'h08, 32'h0);
      chk({26'h0, rd[5:0]}, 32'h3C);
      src_u.iq(5, 16'h0008);
      src_u.iq(4, 16'h0008);
      repeat (8) @(posedge mclk);
      for (int b = 0; b < 16; b++)
      begin
        wb(1'b1, 8'h0C, b);
        wb(1'b0, 8'h10, 32'h0);
        chk(rd, (b == 3) ? 32'd18 : 32'd0);
      end
      wb(1'b1, 8'h00, 32'h02);
      wb(1'b1, 8'h00, 32'h03);
      wb(1'b0, 8'h08, 32'h0);
      chk({30'h0, rd[2:1]}, 32'h0);
      src_u.clk_run(1'b0);
      repeat (300) @(posedge mclk);
      wb(1'b0, 8'h08, 32'h0);
      chk({31'h0, rd[3]}, 32'h0);
      wb(1'b1, 8'h00, 32'h0);
    end
  endtask
  task automatic chk_seg_desc();
    begin
      wb(1'b1, 8'h00, 32'h05);
      src_u.seg(16'hA5C3);
      repeat (6) @(posedge mclk);
      wb(1'b0, 8'h08, 32'h0);
      chk({rd[31:16], 15'h0, rd[0]}, 32'hA5C30001);
      src_u.idle();
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b0, 8'h14, 32'h0);
      chk({16'h0, rd[31:16]}, 32'h0);
      wb(1'b1, 8'h00, 32'h11);
      for (int k = 0; k < 3; k++)
        src_u.pulse(16'h1040 + 16'h0101 * k);
      repeat (6) @(posedge mclk);
      wb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h00031242);
      src_u.pulse(COMMIT_WORD);
      repeat (6) @(posedge mclk);
      wb(1'b0, 8'h14, 32'h0);
      chk(rd, {16'h0004, COMMIT_WORD});
      wb(1'b1, 8'h00, 32'h0);
      wb(1'b1, 8'h00, 32'h09);
      src_u.pulse(16'h2A5C);
      repeat (6) @(posedge mclk);
      wb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'h00012A5C);
      wb(1'b1, 8'h00, 32'h0);
    end
  endtask
  initial
  begin
    rstn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbDatI = 32'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'b1;
    chk_reset();
    chk_modes();
    chk_iq();
    chk_seg_desc();
    tally_and_finish();
  end
endmodule
`default_nettype wire
